/* hdl/can_sched_pkg.sv */
package can_sched_pkg;

  // sizes
  localparam int NUM_BUF = 15;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 6;

  // register word indices
  localparam logic [5:0] ADDR_CTL_BASE = 6'h00;
  localparam logic [5:0] ADDR_STAMP_BASE = 6'h10;
  localparam logic [5:0] ADDR_IRQ_ENABLE = 6'h20;
  localparam logic [5:0] ADDR_IRQ_PENDING = 6'h21;
  localparam logic [5:0] ADDR_IRQ_CLEAR = 6'h22;
  localparam logic [5:0] ADDR_IRQ_CODE_MASK = 6'h23;
  localparam logic [5:0] ADDR_STATUS_PENDING = 6'h24;
  localparam logic [5:0] ADDR_ERROR_DIAG = 6'h25;
  localparam logic [5:0] ADDR_STAMP_COUNTER = 6'h26;
  localparam logic [5:0] ADDR_GLOBAL_CONFIG = 6'h27;

  // buffer control word fields
  localparam int CTL_ST_LSB = 0;
  localparam int CTL_PRI_LSB = 4;
  localparam int CTL_DLC_LSB = 12;
  localparam logic [15:0] CTL_WRITABLE = 16'hf0ff;
  localparam logic [15:0] CTL_RESET = 16'h0000;

  // pending / enable / code mask, global config and status word bit positions
  localparam int ERR_BIT = 15;
  localparam int CFG_STAMP_SYNC_BIT = 0;
  localparam int STP_IRQ_ACTIVE_BIT = 4;

  // buffer states
  localparam logic [3:0] ST_RX_NOT_ACTIVE = 4'h0;
  localparam logic [3:0] ST_RX_READY = 4'h2;
  localparam logic [3:0] ST_RX_FULL = 4'h4;
  localparam logic [3:0] ST_RX_OVERRUN = 4'h6;
  localparam logic [3:0] ST_TX_NOT_ACTIVE = 4'h8;
  localparam logic [3:0] ST_AWAIT_REMOTE = 4'ha;
  localparam logic [3:0] ST_SEND_SINGLE = 4'hc;
  localparam logic [3:0] ST_SEND_SINGLE_LOCKED = 4'hd;
  localparam logic [3:0] ST_SEND_THEN_AWAIT = 4'he;
  localparam logic [3:0] ST_SEND_THEN_AWAIT_LOCKED = 4'hf;

  localparam logic [15:0] STAMP_ZERO = 16'h0000;

  typedef logic [NUM_BUF-1:0][3:0] prio_arr_t;

  // scheduler phase
  typedef enum logic [1:0] {
    SCHED_IDLE = 2'b00,
    SCHED_ON_AIR = 2'b01,
    SCHED_CHAIN = 2'b10
  } sched_e;

  // events from the protocol engine
  typedef struct packed {
    logic bit_tick;
    logic ack_slot;
    logic tx_done;
    logic tx_was_remote;
    logic arb_lost;
    logic bus_idle;
    logic rx_data;
    logic rx_remote;
    logic [3:0] rx_buf;
    logic err_detect;
    logic [15:0] err_bits;
  } link_in_s;

  // request toward the protocol engine
  typedef struct packed {
    logic tx_req;
    logic [3:0] tx_buf;
  } link_out_s;

  // software register port
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

/* hdl/can_rank_pick.sv */
`timescale 1ns/1ps
`default_nettype none
module can_rank_pick
  import can_sched_pkg::*;
(
  input wire logic [can_sched_pkg::NUM_BUF-1:0] cand,
  input wire can_sched_pkg::prio_arr_t prio,
  output logic found,
  output logic [3:0] idx
);
  // smallest rank wins, equal rank goes to lower buffer
  logic [7:0] best;
  always_comb begin
    found = 1'b0;
    idx = 4'h0;
    best = 8'hff;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (cand[i] && (!found || {prio[i], 4'(i)} < best)) begin
        found = 1'b1;
        idx = 4'(i);
        best = {prio[i], 4'(i)};
      end
    end
  end
endmodule
`default_nettype wire

/* hdl/can_tx_sched_irq_timestamp.sv */
// Our own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module can_tx_sched_irq_timestamp
  import can_sched_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire can_sched_pkg::reg_req_s reg_req,
  output logic [can_sched_pkg::DATA_W-1:0] reg_rdata,
  input wire can_sched_pkg::link_in_s link_in,
  output can_sched_pkg::link_out_s link_out,
  output logic irq,
  output logic wake_rx
);

  // complete block state
  typedef struct packed {
    logic [NUM_BUF-1:0][15:0] ctl;
    logic [NUM_BUF-1:0][15:0] stamp;
    logic [15:0] irq_enable_mask;
    logic [15:0] irq_pending_flags;
    logic [15:0] irq_code_mask;
    logic [15:0] error_diag_word;
    logic [15:0] stamp_counter;
    logic [15:0] ack_stamp;
    logic [15:0] global_config;
    sched_e phase;
    logic [3:0] cur_buf;
    link_out_s lout;
    logic irq;
    logic wake;
    logic [15:0] rdata;
  } state_s;

  state_s cur; // registered state
  state_s next_cur; // next state

  // send request codes
  function automatic logic wants_send(input logic [3:0] st);
    wants_send = (st == ST_SEND_SINGLE) || (st == ST_SEND_THEN_AWAIT);
  endfunction

  // locked means transmit state with busy bit
  function automatic logic is_locked(input logic [3:0] st);
    is_locked = st[3] && st[0];
  endfunction

  // coded request: active bit and source code
  function automatic logic [4:0] encode(input logic [15:0] req);
    logic [4:0] r;
    r = 5'h00;
    // error outranks buffers, low buffer first
    if (req[ERR_BIT]) begin
      r = 5'h10;
    end else begin
      for (int i = NUM_BUF - 1; i >= 0; i--) begin
        if (req[i]) begin
          r = {1'b1, 4'(i + 1)};
        end
      end
    end
    encode = r;
  endfunction

  // candidate set and picker
  logic [NUM_BUF-1:0] cand;
  prio_arr_t prio;
  logic pick_found;
  logic [3:0] pick_idx;

  // scheduler candidates exclude the buffer on air
  always_comb begin
    for (int i = 0; i < NUM_BUF; i++) begin
      cand[i] = wants_send(cur.ctl[i][3:0]);
      prio[i] = cur.ctl[i][CTL_PRI_LSB +: 4];
    end
  end

  can_rank_pick u_pick (
    .cand(cand),
    .prio(prio),
    .found(pick_found),
    .idx(pick_idx)
  );

  // next-state logic
  always_comb begin
    logic [3:0] st;
    logic [15:0] ev;
    logic [4:0] code;
    logic [3:0] b;
    logic locked_w;
    st = 4'h0;
    ev = 16'h0000;
    code = 5'h00;
    b = 4'h0;
    locked_w = 1'b0;
    next_cur = cur;
    next_cur.wake = 1'b0;
    next_cur.rdata = 16'h0000;

    // software writes
    if (reg_req.wr) begin
      b = reg_req.addr[3:0];
      if (reg_req.addr[5:4] == ADDR_CTL_BASE[5:4] && b < 4'(NUM_BUF)) begin
        locked_w = is_locked(cur.ctl[b][3:0]);
        if (locked_w) begin
          // only upper status bits, busy bit cleared, write dropped while on air
          if (!(cur.phase == SCHED_ON_AIR && cur.cur_buf == b)) begin
            next_cur.ctl[b][3:0] = {reg_req.wdata[3:1], 1'b0};
          end
        end else begin
          next_cur.ctl[b] = reg_req.wdata & CTL_WRITABLE;
        end
      end else if (reg_req.addr[5:4] == ADDR_STAMP_BASE[5:4] && b < 4'(NUM_BUF)) begin
        // stamp word blocked while locked
        if (!is_locked(cur.ctl[b][3:0])) begin
          next_cur.stamp[b] = reg_req.wdata;
        end
      end else begin
        case (reg_req.addr)
          ADDR_IRQ_ENABLE: next_cur.irq_enable_mask = reg_req.wdata;
          ADDR_IRQ_CLEAR: next_cur.irq_pending_flags = cur.irq_pending_flags & ~reg_req.wdata;
          ADDR_IRQ_CODE_MASK: next_cur.irq_code_mask = reg_req.wdata;
          ADDR_ERROR_DIAG: next_cur.error_diag_word = cur.error_diag_word & ~reg_req.wdata;
          ADDR_STAMP_COUNTER: next_cur.stamp_counter = reg_req.wdata;
          ADDR_GLOBAL_CONFIG: next_cur.global_config = reg_req.wdata & 16'h0001;
          default: ;
        endcase
      end
    end

    if (link_in.bit_tick) begin
      next_cur.stamp_counter = next_cur.stamp_counter + 16'h0001;
    end
    // sample counter in the ack slot
    if (link_in.ack_slot) begin
      next_cur.ack_stamp = cur.stamp_counter;
    end

    // transmit completion
    if (cur.phase == SCHED_ON_AIR && link_in.tx_done) begin
      b = cur.cur_buf;
      st = cur.ctl[b][3:0];
      if (st == ST_SEND_THEN_AWAIT_LOCKED) begin
        next_cur.ctl[b][3:0] = ST_AWAIT_REMOTE;
      end else if (link_in.tx_was_remote) begin
        next_cur.ctl[b][3:0] = ST_RX_READY;
      end else begin
        // data frame sent, back to idle
        next_cur.ctl[b][3:0] = ST_TX_NOT_ACTIVE;
      end
      ev[b] = 1'b1;
      next_cur.stamp[b] = cur.ack_stamp;
      if (b == 4'h0 && cur.global_config[CFG_STAMP_SYNC_BIT]) begin
        next_cur.stamp_counter = STAMP_ZERO;
      end
      // go straight for the next frame
      next_cur.phase = SCHED_CHAIN;
      next_cur.lout.tx_req = 1'b0;
    end else if (cur.phase == SCHED_ON_AIR && link_in.arb_lost) begin
      // lost arbitration clears the busy bit and returns to idle
      next_cur.ctl[cur.cur_buf][0] = 1'b0;
      next_cur.phase = SCHED_IDLE;
      next_cur.lout.tx_req = 1'b0;
    end

    // received frames
    if (link_in.rx_data && link_in.rx_buf < 4'(NUM_BUF)) begin
      b = link_in.rx_buf;
      st = cur.ctl[b][3:0];
      if (st == ST_RX_READY || st == ST_RX_FULL) begin
        next_cur.ctl[b][3:0] = (st == ST_RX_READY) ? ST_RX_FULL : ST_RX_OVERRUN;
        ev[b] = 1'b1;
        next_cur.stamp[b] = cur.ack_stamp;
        if (b == 4'h0 && cur.global_config[CFG_STAMP_SYNC_BIT]) begin
          next_cur.stamp_counter = STAMP_ZERO;
        end
        // data receive event to wakeup unit
        next_cur.wake = 1'b1;
      end
    end
    if (link_in.rx_remote && link_in.rx_buf < 4'(NUM_BUF)) begin
      b = link_in.rx_buf;
      // awaiting buffer sends nothing until here
      // remote frame schedules the data answer
      if (cur.ctl[b][3:0] == ST_AWAIT_REMOTE) begin
        next_cur.ctl[b][3:0] = ST_SEND_THEN_AWAIT;
        ev[b] = 1'b1;
      end
    end

    if (link_in.err_detect) begin
      ev[ERR_BIT] = 1'b1;
      next_cur.error_diag_word = next_cur.error_diag_word | link_in.err_bits;
    end
    // set wins over clear
    next_cur.irq_pending_flags = next_cur.irq_pending_flags | ev;

    // scheduler
    case (cur.phase)
      SCHED_IDLE: begin
        if (link_in.bus_idle && pick_found) begin
          next_cur.ctl[pick_idx][0] = 1'b1;
          next_cur.cur_buf = pick_idx;
          next_cur.lout.tx_req = 1'b1;
          next_cur.lout.tx_buf = pick_idx;
          next_cur.phase = SCHED_ON_AIR;
        end
      end
      SCHED_CHAIN: begin
        // no wait for idle bus between frames
        if (pick_found) begin
          next_cur.ctl[pick_idx][0] = 1'b1;
          next_cur.cur_buf = pick_idx;
          next_cur.lout.tx_req = 1'b1;
          next_cur.lout.tx_buf = pick_idx;
          next_cur.phase = SCHED_ON_AIR;
        end else begin
          next_cur.phase = SCHED_IDLE;
        end
      end
      SCHED_ON_AIR: ;
      default: next_cur.phase = SCHED_IDLE;
    endcase

    // one request line for all sources
    next_cur.irq = |(next_cur.irq_pending_flags & next_cur.irq_enable_mask);

    // reads, data in the following cycle
    if (reg_req.rd) begin
      b = reg_req.addr[3:0];
      if (reg_req.addr[5:4] == ADDR_CTL_BASE[5:4] && b < 4'(NUM_BUF)) begin
        next_cur.rdata = cur.ctl[b] & CTL_WRITABLE;
      end else if (reg_req.addr[5:4] == ADDR_STAMP_BASE[5:4] && b < 4'(NUM_BUF)) begin
        next_cur.rdata = cur.stamp[b];
      end else begin
        case (reg_req.addr)
          ADDR_IRQ_ENABLE: next_cur.rdata = cur.irq_enable_mask;
          ADDR_IRQ_PENDING: next_cur.rdata = cur.irq_pending_flags;
          ADDR_IRQ_CODE_MASK: next_cur.rdata = cur.irq_code_mask;
          ADDR_STATUS_PENDING: begin
            code = encode(cur.irq_pending_flags & cur.irq_code_mask);
            next_cur.rdata = {11'h000, code};
          end
          ADDR_ERROR_DIAG: next_cur.rdata = cur.error_diag_word;
          ADDR_STAMP_COUNTER: next_cur.rdata = cur.stamp_counter;
          ADDR_GLOBAL_CONFIG: next_cur.rdata = cur.global_config;
          default: next_cur.rdata = 16'h0000;
        endcase
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs straight from flops
  assign reg_rdata = cur.rdata;
  assign link_out = cur.lout;
  assign irq = cur.irq;
  assign wake_rx = cur.wake;

endmodule
`default_nettype wire

/* test/can_tx_sched_irq_timestamp_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module can_tx_sched_checker (
  input wire logic clk,
  input wire logic rst_b,
  input wire can_sched_pkg::reg_req_s reg_req,
  input wire logic [can_sched_pkg::DATA_W-1:0] reg_rdata,
  input wire can_sched_pkg::link_in_s link_in,
  input wire can_sched_pkg::link_out_s link_out,
  input wire logic irq,
  input wire logic wake_rx
);
  import can_sched_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  clear_reads_zero_a: assert property (reg_req.rd && reg_req.addr == ADDR_IRQ_CLEAR |=> reg_rdata == 16'h0000)
    else $error("clear word read not zero");
  request_holds_a: assert property (link_out.tx_req && !link_in.tx_done && !link_in.arb_lost
    |=> link_out.tx_req && $stable(link_out.tx_buf)) else $error("send request dropped early");
  done_drops_a: assert property (link_out.tx_req && link_in.tx_done |=> !link_out.tx_req)
    else $error("request kept after completion");
  chain_start_a: assert property ($rose(link_out.tx_req)
    |-> $past(link_in.bus_idle) || $past(link_in.tx_done, 2)) else $error("send started without cause");
  wake_pulse_a: assert property (wake_rx |=> !wake_rx)
    else $error("wake pulse too long");
  wake_cause_a: assert property (wake_rx |-> $past(link_in.rx_data))
    else $error("wake without received frame");
  irq_cause_a: assert property ($rose(irq)
    |-> $past(link_in.tx_done || link_in.rx_data || link_in.rx_remote || link_in.err_detect || reg_req.wr))
    else $error("interrupt without event");
  irq_holds_a: assert property (irq && !reg_req.wr |=> irq)
    else $error("interrupt fell without write");
endmodule
bind can_tx_sched_irq_timestamp can_tx_sched_checker u_chk (.clk(clk), .rst_b(rst_b), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .link_in(link_in), .link_out(link_out), .irq(irq), .wake_rx(wake_rx));
`default_nettype wire

/* test/can_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module can_link_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire can_sched_pkg::link_out_s link_out,
  output can_sched_pkg::link_in_s link_in
);
  import can_sched_pkg::*;
  int delay = 3; // frame length in cycles
  logic remote = 1'b0; // frames sent are remote requests
  logic idle = 1'b0; // bus free when nothing is on air
  logic [3:0] sent[$]; // buffers in the order sent
  int cnt = 0; // cycles on air
  logic lose = 1'b0; // lose arbitration once on the next frame
  initial link_in = '0;
  // frame timing: ack slot, then completion
  always @(posedge clk) begin
    link_in.bus_idle <= idle && !link_out.tx_req;
    link_in.tx_was_remote <= remote;
    link_in.ack_slot <= link_out.tx_req && cnt == delay - 1;
    link_in.tx_done <= 1'b0;
    link_in.arb_lost <= 1'b0;
    cnt <= (!link_out.tx_req || link_in.tx_done) ? 0 : cnt + 1;
    // another node wins early in the frame, nothing logged
    if (lose && link_out.tx_req && cnt == 1) begin
      link_in.arb_lost <= 1'b1;
      lose <= 1'b0;
    end
    if (link_out.tx_req && !link_in.tx_done && cnt == delay) begin
      link_in.tx_done <= 1'b1;
      sent.push_back(link_out.tx_buf);
    end
  end
  // one-cycle receive, remote or error event
  task automatic pulse(input logic dat, input logic rmt, input logic [3:0] b, input logic [15:0] err);
    link_in.rx_data <= dat;
    link_in.rx_remote <= rmt;
    link_in.rx_buf <= b;
    link_in.err_detect <= |err;
    link_in.err_bits <= err;
    @(posedge clk);
    link_in.rx_data <= 1'b0;
    link_in.rx_remote <= 1'b0;
    link_in.err_detect <= 1'b0;
  endtask
  // bit times seen on the bus
  task automatic ticks(input int n);
    repeat (n) begin
      link_in.bit_tick <= 1'b1;
      @(posedge clk);
      link_in.bit_tick <= 1'b0;
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* test/can_tx_sched_irq_timestamp_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module can_tx_sched_irq_timestamp_tb_top;
  import can_sched_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_s req = '0;
  logic [15:0] rdata;
  logic [15:0] rq;
  link_in_s lin;
  link_out_s lout;
  logic irq;
  logic wake_rx;
  int fails = 0;
  int check_count = 0;
  int wakes = 0;
  initial forever #50 clk = ~clk;
  // count wake pulses
  always @(posedge clk) if (wake_rx === 1'b1) wakes <= wakes + 1;
  can_tx_sched_irq_timestamp u_dut (.clk(clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata),
    .link_in(lin), .link_out(lout), .irq(irq), .wake_rx(wake_rx));
  can_link_model u_link (.clk(clk), .rst_b(rst_b), .link_out(lout), .link_in(lin));
  function automatic logic [5:0] ctl(input int n);
    return ADDR_CTL_BASE + 6'(n);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobe cycle, one idle cycle
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= w;
    req.rd <= !w;
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1 rq = rdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(rq, e);
  endtask
  // look off the edge, hand back on an edge
  task automatic chk_irq(input logic e);
    @(posedge clk);
    #1 chk({15'h0000, irq}, {15'h0000, e});
    @(posedge clk);
  endtask
  // bounded wait for n frames on the bus
  task automatic wait_sent(input int n);
    for (int k = 0; k < 500 && u_link.sent.size() < n; k++) @(posedge clk);
    // completion lands in the design one edge after the model logs it
    @(posedge clk);
    chk(16'(u_link.sent.size()), 16'(n));
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog well past the expected run
  initial begin
    #1000000;
    fails++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    wr(ADDR_IRQ_CODE_MASK, 16'hffff);
    rd(6'h3f, 16'h0000);
    rd(ADDR_IRQ_CLEAR, 16'h0000);
    rd(ctl(0), CTL_RESET);
    wr(ctl(3), 16'h0018);
    wr(ctl(3), 16'h001c);
    wr(ctl(5), 16'h000c);
    wr(ctl(2), 16'h001c);
    u_link.idle <= 1'b1;
    @(posedge clk);
    u_link.idle <= 1'b0;
    wait_sent(3);
    chk({12'h000, u_link.sent[0]}, 16'h0005);
    chk({12'h000, u_link.sent[1]}, 16'h0002);
    chk({12'h000, u_link.sent[2]}, 16'h0003);
    rd(ctl(5), 16'h0008);
    rd(ctl(3), 16'h0018);
    rd(ADDR_IRQ_PENDING, 16'h002c);
    rd(ADDR_STATUS_PENDING, 16'h0013);
    wr(ADDR_IRQ_CODE_MASK, 16'h0020);
    rd(ADDR_STATUS_PENDING, 16'h0016);
    wr(ADDR_IRQ_CODE_MASK, 16'hffff);
    $display("schedule test done");
    u_link.pulse(1'b0, 1'b0, 4'h0, 16'h0003);
    rd(ADDR_ERROR_DIAG, 16'h0003);
    rd(ADDR_IRQ_PENDING, 16'h802c);
    rd(ADDR_STATUS_PENDING, 16'h0010);
    chk_irq(1'b0);
    wr(ADDR_IRQ_ENABLE, 16'h8000);
    chk_irq(1'b1);
    wr(ADDR_IRQ_CLEAR, 16'h802c);
    rd(ADDR_IRQ_PENDING, 16'h0000);
    rd(ADDR_STATUS_PENDING, 16'h0000);
    chk_irq(1'b0);
    $display("interrupt test done");
    u_link.delay <= 20;
    u_link.idle <= 1'b1;
    wr(ADDR_STAMP_COUNTER, 16'h1234);
    wr(ctl(7), 16'h000c);
    rd(ctl(7), 16'h000d);
    wr(ctl(7), 16'h0008);
    wr(ADDR_STAMP_BASE + 6'd7, 16'hbeef);
    rd(ctl(7), 16'h000d);
    wait_sent(4);
    rd(ADDR_STAMP_BASE + 6'd7, 16'h1234);
    rd(ctl(7), 16'h0008);
    wr(ctl(4), 16'h000e);
    rd(ctl(4), 16'h000f);
    wait_sent(5);
    rd(ctl(4), 16'h000a);
    u_link.delay <= 3;
    u_link.pulse(1'b0, 1'b1, 4'h4, 16'h0000);
    wait_sent(6);
    rd(ctl(4), 16'h000a);
    wr(ctl(6), 16'h000a);
    repeat (30) @(posedge clk);
    chk(16'(u_link.sent.size()), 16'h0006);
    rd(ctl(6), 16'h000a);
    $display("send state test done");
    wr(ADDR_GLOBAL_CONFIG, 16'h0001);
    wr(ctl(0), 16'h000c);
    wait_sent(7);
    rd(ADDR_STAMP_BASE, 16'h1234);
    rd(ADDR_STAMP_COUNTER, STAMP_ZERO);
    wr(ADDR_STAMP_COUNTER, 16'hfffe);
    u_link.ticks(3);
    rd(ADDR_STAMP_COUNTER, 16'h0001);
    $display("stamp test done");
    u_link.remote <= 1'b1;
    wr(ctl(1), 16'h000c);
    wait_sent(8);
    u_link.remote <= 1'b0;
    rd(ctl(1), 16'h0002);
    u_link.pulse(1'b1, 1'b0, 4'h1, 16'h0000);
    rd(ctl(1), 16'h0004);
    chk(16'(wakes), 16'h0001);
    rd(ADDR_IRQ_PENDING, 16'h0093);
    $display("remote test done");
    u_link.lose <= 1'b1;
    wr(ctl(8), 16'h000c);
    wait_sent(9);
    chk({15'h0000, u_link.lose}, 16'h0000);
    chk({12'h000, u_link.sent[8]}, 16'h0008);
    rd(ctl(8), 16'h0008);
    $display("lost arbitration test done");
    test_done();
  end
endmodule
`default_nettype wire
